// *** hw/qdac_device.sv ***
// Converter side: serial frame receiver, command decode and channel registers
// How it works
// - host lowers frame select before first bit
// - sample data on each serial clock fall
// - 24th fall completes frame, then shifter frozen
// - top eight bits control, low sixteen data
// - execute immediately after the 24th fall
// - new frame opens only at select fall
// - early select rise discards partial frame
// - select may stay low or rise after
// - host keeps gap before next select fall
// - clear forces outputs to zero or midscale
// - clear resets every internal register
// - host releases clear before any frame
// - level select fixed from power-up; the pin is read live here, so a later change moves the outputs at once
// - each channel holds unsigned 16-bit code
// - binary or two's complement input coding
// - bits 18:17 pick channel, 19 ignored
// - load command bits choose four update actions
// - power-down flag turns bits 15:14 into mode
// - strobe rise loads all channels from buffers
`timescale 1ns/1ps
module qdac_device (
  input  wire logic                                                  sys_clk_i,
  input  wire logic                                                  reset_i,
  qdac_link_if.dev_mp                                                link,
  output logic [qdac_pkg::CHANNELS-1:0][qdac_pkg::DATA_W-1:0]        dac_code_o,
  output logic [qdac_pkg::CHANNELS-1:0]                              dac_pd_o,
  output logic [qdac_pkg::CHANNELS-1:0][qdac_pkg::PD_MODE_W-1:0]     dac_pd_mode_o,
  output logic                                                       frame_done_o,
  output logic                                                       frame_abort_o
);
  import qdac_pkg::*;

  logic                                  arst;
  logic [PIN_N-1:0]                      pins_raw;
  logic [PIN_N-1:0]                      s1_reg;
  logic [PIN_N-1:0]                      s2_reg;
  logic [PIN_N-1:0]                      s3_reg;
  logic [PIN_N-1:0]                      lvl_reg;
  logic [PIN_N-1:0]                      lvl_prev_reg;
  logic                                  sclk_fall;
  logic                                  sync_fall;
  logic                                  sync_rise;
  logic                                  load_all_strobe_rise;
  logic                                  frame_open_reg;
  logic [CNT_W-1:0]                      bit_cnt_reg;
  logic [FRAME_BITS-1:0]                 shift_reg;
  logic                                  exec_reg;
  logic                                  abort_reg;
  logic [1:0]                            load_cmd;
  logic [SEL_W-1:0]                      chan_sel;
  qdac_entry_t                           entry;
  qdac_entry_t [CHANNELS-1:0]            buf_reg;
  qdac_entry_t [CHANNELS-1:0]            buf_next;
  qdac_entry_t [CHANNELS-1:0]            dac_reg;
  qdac_entry_t [CHANNELS-1:0]            dac_next;
  logic [DATA_W-1:0]                     code_mask;

  // The clear pin acts directly on every flop, like the power-on reset
  assign arst = reset_i | ~link.clear_n;

  assign pins_raw = {link.load_all_strobe, link.sync_n, link.sclk, link.din};

  // Three-stage capture of the pins; a level is taken only when stages two and three agree
  always_ff @(posedge sys_clk_i or posedge arst) begin
    if (arst) begin
      s1_reg <= PINS_IDLE;
      s2_reg <= PINS_IDLE;
      s3_reg <= PINS_IDLE;
    end else begin
      s1_reg <= pins_raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  always_ff @(posedge sys_clk_i or posedge arst) begin
    if (arst) begin
      lvl_reg      <= PINS_IDLE;
      lvl_prev_reg <= PINS_IDLE;
    end else begin
      lvl_reg      <= ((s2_reg ~^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & lvl_reg);
      lvl_prev_reg <= lvl_reg;
    end
  end

  assign sclk_fall = lvl_prev_reg[PIN_SCLK] & ~lvl_reg[PIN_SCLK];
  assign sync_fall = lvl_prev_reg[PIN_SYNC] & ~lvl_reg[PIN_SYNC];
  assign sync_rise = ~lvl_prev_reg[PIN_SYNC] & lvl_reg[PIN_SYNC];
  assign load_all_strobe_rise = ~lvl_prev_reg[PIN_LOAD_ALL_STROBE] & lvl_reg[PIN_LOAD_ALL_STROBE];

  // Frame tracking: select opens and closes, the counter never runs past a full frame
  always_ff @(posedge sys_clk_i or posedge arst) begin
    if (arst) begin
      frame_open_reg <= 1'b0;
      bit_cnt_reg    <= '0;
      abort_reg      <= 1'b0;
    end else begin
      abort_reg <= 1'b0;
      if (sync_fall) begin
        frame_open_reg <= 1'b1;
        bit_cnt_reg    <= '0;
      end else if (sync_rise) begin
        frame_open_reg <= 1'b0;
        bit_cnt_reg    <= '0;
        abort_reg      <= frame_open_reg & (bit_cnt_reg != FRAME_FULL);
      end else if (frame_open_reg && sclk_fall && bit_cnt_reg != FRAME_FULL) begin
        bit_cnt_reg <= bit_cnt_reg + 1'b1;
      end
    end
  end

  // First sampled bit ends up at the top of the word
  always_ff @(posedge sys_clk_i or posedge arst) begin
    if (arst) begin
      shift_reg <= '0;
    end else if (frame_open_reg && !sync_rise && !sync_fall && sclk_fall && bit_cnt_reg != FRAME_FULL) begin
      shift_reg <= {shift_reg[FRAME_BITS-2:0], lvl_reg[PIN_DIN]};
    end
  end

  // One-cycle execute pulse in the cycle after the last bit lands, whatever select does next
  always_ff @(posedge sys_clk_i or posedge arst) begin
    if (arst) begin
      exec_reg <= 1'b0;
    end else begin
      exec_reg <= frame_open_reg & ~sync_rise & ~sync_fall & sclk_fall &
                  (bit_cnt_reg == LAST_BIT_IDX);
    end
  end

  assign frame_done_o  = exec_reg;
  assign frame_abort_o = abort_reg;

  // Field split of the locked word; bits 23, 22 and 19 are not looked at
  assign load_cmd = shift_reg[LOAD_HI_BIT:LOAD_LO_BIT];
  assign chan_sel = shift_reg[SEL_HI_BIT:SEL_LO_BIT];

  // A power-down entry keeps only the mode bits; the data field is dropped
  always_comb begin
    if (shift_reg[PD_FLAG_BIT]) begin
      entry = {1'b1, shift_reg[PD_MODE_HI:PD_MODE_LO], {(DATA_W-PD_MODE_W){1'b0}}};
    end else begin
      entry = {1'b0, shift_reg[DATA_W-1:0]};
    end
  end

  // Buffer and output register updates; a strobe in the same cycle sees the new buffers
  always_comb begin
    buf_next = buf_reg;
    dac_next = dac_reg;
    if (exec_reg) begin
      case (qdac_load_e'(load_cmd))
        LOAD_STORE: begin
          buf_next[chan_sel] = entry;
        end
        LOAD_UPDATE: begin
          buf_next[chan_sel] = entry;
          dac_next[chan_sel] = entry;
        end
        LOAD_SIMUL: begin
          buf_next[chan_sel] = entry;
          dac_next           = buf_next;
        end
        LOAD_BCAST: begin
          if (shift_reg[SEL_HI_BIT]) begin
            for (int i = 0; i < CHANNELS; i++) begin
              buf_next[i] = entry;
              dac_next[i] = entry;
            end
          end else begin
            dac_next = buf_next;
          end
        end
        default: begin
          dac_next = dac_reg;
        end
      endcase
    end
    if (load_all_strobe_rise) begin
      dac_next = buf_next;
    end
  end

  always_ff @(posedge sys_clk_i or posedge arst) begin
    if (arst) begin
      for (int i = 0; i < CHANNELS; i++) begin
        buf_reg[i] <= ENTRY_RESET;
      end
    end else begin
      buf_reg <= buf_next;
    end
  end

  always_ff @(posedge sys_clk_i or posedge arst) begin
    if (arst) begin
      for (int i = 0; i < CHANNELS; i++) begin
        dac_reg[i] <= ENTRY_RESET;
      end
    end else begin
      dac_reg <= dac_next;
    end
  end

  // Registers keep the raw input code. In two's complement mode the sign bit is flipped
  // on the way out, so the all-zero reset code lands at midscale without a port in the
  // reset branch. The select pin is read live so a clear takes effect at once; it is
  // expected to stay put after power-up.
  assign code_mask = link.clear_level_select ? TWOS_MASK : '0;

  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      dac_code_o[i]    = dac_reg[i][DATA_W-1:0] ^ code_mask;
      dac_pd_o[i]      = dac_reg[i][ENTRY_PD_BIT];
      dac_pd_mode_o[i] = dac_reg[i][PD_MODE_HI:PD_MODE_LO];
    end
  end

endmodule // qdac_device

// *** hw/qdac_pkg.sv ***
// Shared constants and types for the quad converter serial link and its host
package qdac_pkg;

  // Frame geometry
  localparam int FRAME_BITS  = 24;
  localparam int CNT_W       = 5;
  localparam int CHANNELS    = 4;
  localparam int SEL_W       = 2;
  localparam int DATA_W      = 16;
  localparam int ENTRY_W     = DATA_W + 1;
  localparam int PD_MODE_W   = 2;

  // Field positions inside the 24-bit frame
  localparam int LOAD_HI_BIT = 21;
  localparam int LOAD_LO_BIT = 20;
  localparam int SEL_HI_BIT  = 18;
  localparam int SEL_LO_BIT  = 17;
  localparam int PD_FLAG_BIT = 16;
  localparam int PD_MODE_HI  = 15;
  localparam int PD_MODE_LO  = 14;

  // Field position of the power-down flag inside a stored channel entry
  localparam int ENTRY_PD_BIT = 16;

  localparam logic [CNT_W-1:0]   LAST_BIT_IDX = 5'h17;
  localparam logic [CNT_W-1:0]   FRAME_FULL   = 5'h18;
  localparam logic [DATA_W-1:0]  TWOS_MASK    = 16'h8000;
  localparam logic [ENTRY_W-1:0] ENTRY_RESET  = 17'h00000;

  // Sampled pin vector on the device side: {strobe, select, clock, data}
  localparam int PIN_N    = 4;
  localparam int PIN_DIN  = 0;
  localparam int PIN_SCLK = 1;
  localparam int PIN_SYNC = 2;
  localparam int PIN_LOAD_ALL_STROBE = 3;
  localparam logic [PIN_N-1:0] PINS_IDLE = 4'h4;

  // Timing, in ns, and the derived counts at the system clock rate
  localparam int SYS_CLK_MHZ    = 200;
  localparam int GAP_NS         = 130;
  localparam int SYNC_HIGH_NS   = 40;
  localparam int GAP_CYC        = (GAP_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int SYNC_HIGH_CYC  = (SYNC_HIGH_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int SCLK_HALF_DEF  = 16;
  localparam int TIMER_W        = 8;

  typedef enum logic [1:0] {
    LOAD_STORE  = 2'h0,
    LOAD_UPDATE = 2'h1,
    LOAD_SIMUL  = 2'h2,
    LOAD_BCAST  = 2'h3
  } qdac_load_e;

  typedef enum logic [1:0] {
    PD_HIZ_A  = 2'h0,
    PD_1K     = 2'h1,
    PD_100K   = 2'h2,
    PD_HIZ_B  = 2'h3
  } qdac_pd_mode_e;

  typedef logic [ENTRY_W-1:0] qdac_entry_t;

endpackage

// *** hw/qdac_link_if.sv ***
// Serial link and clear pins between the host controller and the converter
`timescale 1ns/1ps
interface qdac_link_if;
  logic sync_n;
  logic sclk;
  logic din;
  logic clear_n;
  logic clear_level_select;
  logic load_all_strobe;

  modport host_mp (
    output sync_n,
    output sclk,
    output din,
    output clear_n,
    output clear_level_select,
    output load_all_strobe
  );

  modport dev_mp (
    input sync_n,
    input sclk,
    input din,
    input clear_n,
    input clear_level_select,
    input load_all_strobe
  );
endinterface

// *** hw/qdac_host.sv ***
// Host side: frames 24-bit words onto the link and drives clear and strobe pins
`timescale 1ns/1ps
module qdac_host #(
  parameter int SCLK_HALF = qdac_pkg::SCLK_HALF_DEF
) (
  input  wire logic                              sys_clk_i,
  input  wire logic                              reset_i,
  qdac_link_if.host_mp                           link,
  input  wire logic                              start_i,
  input  wire logic [qdac_pkg::FRAME_BITS-1:0]   frame_i,
  input  wire logic                              clear_i,
  input  wire logic                              level_select_i,
  input  wire logic                              load_all_i,
  output logic                                   ready_o,
  output logic                                   busy_o,
  output logic                                   done_o
);
  import qdac_pkg::*;

  localparam int GAP_HOLD = (GAP_CYC > SYNC_HIGH_CYC) ? GAP_CYC : SYNC_HIGH_CYC;
  localparam logic [TIMER_W-1:0] HALF_LOAD = TIMER_W'(SCLK_HALF - 1);
  localparam logic [TIMER_W-1:0] GAP_LOAD  = TIMER_W'(GAP_HOLD - 1);

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_HIGH = 4'h2,
    ST_LOW  = 4'h4,
    ST_GAP  = 4'h8
  } qdac_host_state_e;

  qdac_host_state_e              state_reg;
  logic [TIMER_W-1:0]            timer_reg;
  logic [CNT_W-1:0]              sent_reg;
  logic [FRAME_BITS-1:0]         frame_reg;
  logic                          sync_n_reg;
  logic                          sclk_reg;
  logic                          din_reg;
  logic                          done_reg;
  logic                          clear_n_reg;
  logic                          level_reg;
  logic                          load_all_reg;

  assign link.sync_n             = sync_n_reg;
  assign link.sclk               = sclk_reg;
  assign link.din                = din_reg;
  assign link.clear_n            = clear_n_reg;
  assign link.clear_level_select = level_reg;
  assign link.load_all_strobe    = load_all_reg;

  // No frame may start while clear is held or requested
  assign ready_o = (state_reg == ST_IDLE) & clear_n_reg & ~clear_i;
  assign busy_o  = (state_reg != ST_IDLE);
  assign done_o  = done_reg;

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      clear_n_reg  <= 1'b0;
      level_reg    <= 1'b0;
      load_all_reg <= 1'b0;
    end else begin
      clear_n_reg  <= ~clear_i;
      level_reg    <= level_select_i;
      load_all_reg <= load_all_i;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg  <= ST_IDLE;
      timer_reg  <= '0;
      sent_reg   <= '0;
      frame_reg  <= '0;
      sync_n_reg <= 1'b1;
      sclk_reg   <= 1'b0;
      din_reg    <= 1'b0;
      done_reg   <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (start_i && ready_o) begin
            sync_n_reg <= 1'b0;
            sclk_reg   <= 1'b1;
            din_reg    <= frame_i[FRAME_BITS-1];
            frame_reg  <= {frame_i[FRAME_BITS-2:0], 1'b0};
            sent_reg   <= '0;
            timer_reg  <= HALF_LOAD;
            state_reg  <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          if (timer_reg == '0) begin
            sclk_reg  <= 1'b0;
            sent_reg  <= sent_reg + 1'b1;
            timer_reg <= HALF_LOAD;
            state_reg <= ST_LOW;
          end else begin
            timer_reg <= timer_reg - 1'b1;
          end
        end
        ST_LOW: begin
          if (timer_reg != '0) begin
            timer_reg <= timer_reg - 1'b1;
          end else if (sent_reg == FRAME_FULL) begin
            sync_n_reg <= 1'b1;
            timer_reg  <= GAP_LOAD;
            state_reg  <= ST_GAP;
          end else begin
            sclk_reg  <= 1'b1;
            din_reg   <= frame_reg[FRAME_BITS-1];
            frame_reg <= {frame_reg[FRAME_BITS-2:0], 1'b0};
            timer_reg <= HALF_LOAD;
            state_reg <= ST_HIGH;
          end
        end
        ST_GAP: begin
          // Select stays high long enough for both the high time and the inter-frame gap
          if (timer_reg == '0) begin
            done_reg  <= 1'b1;
            state_reg <= ST_IDLE;
          end else begin
            timer_reg <= timer_reg - 1'b1;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // qdac_host

// *** verification/qdac_link_sva.sv ***
// Protocol assertions on the host-to-converter serial link
`timescale 1ns/1ps
module qdac_link_sva #(
  parameter int SCLK_HALF = qdac_pkg::SCLK_HALF_DEF
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic sync_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic clear_n,
  input wire logic frame_done_o,
  input wire logic frame_abort_o
);
  import qdac_pkg::*;
  localparam int HALF_M1 = SCLK_HALF - 1;
  logic       sclk_q;
  logic       sync_q;
  logic [4:0] fall_cnt;
  logic [7:0] gap_cnt;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sclk_q <= 1'b0;
      sync_q <= 1'b1;
    end else begin
      sclk_q <= sclk;
      sync_q <= sync_n;
    end
  end

  // Cleared only by a select fall, so the count survives until the late done pulse
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      fall_cnt <= 5'h00;
    end else if (sync_q && !sync_n) begin
      fall_cnt <= 5'h00;
    end else if (sclk_q && !sclk && !sync_n) begin
      fall_cnt <= fall_cnt + 5'h01;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      gap_cnt <= 8'hff;
    end else if (sclk_q && !sclk && !sync_n && fall_cnt == LAST_BIT_IDX) begin
      gap_cnt <= 8'h00;
    end else if (gap_cnt != 8'hff) begin
      gap_cnt <= gap_cnt + 8'h01;
    end
  end

  sequence seq_last_fall;
    $fell(sclk) && !sync_n && fall_cnt == LAST_BIT_IDX;
  endsequence
  sequence seq_open;
    $fell(sync_n) ##0 $rose(sclk);
  endsequence

  a_idle_clock_low: assert property (sync_n |-> !sclk)
    else $error("serial clock not low while select high");
  a_open_first_bit: assert property ($fell(sync_n) |-> seq_open)
    else $error("frame opened without first clock rise");
  a_sclk_high_half: assert property ($rose(sclk) |-> ##HALF_M1 sclk ##1 !sclk)
    else $error("serial clock high phase wrong length");
  a_sclk_low_half: assert property ($fell(sclk) && !sync_n && fall_cnt < LAST_BIT_IDX |-> ##HALF_M1 !sclk ##1 sclk)
    else $error("serial clock low phase wrong length");
  a_din_setup_hold: assert property (!sync_n && sclk && !$rose(sclk) |-> $stable(din))
    else $error("data moved while clock high");
  a_full_frame: assert property ($rose(sync_n) |-> fall_cnt == FRAME_FULL)
    else $error("select rose without full frame");
  a_done_bound: assert property (seq_last_fall |-> ##[1:10] frame_done_o)
    else $error("frame not executed after last clock fall");
  a_done_only_full: assert property (frame_done_o |-> fall_cnt == FRAME_FULL)
    else $error("frame executed before full count");
  a_no_abort: assert property (!frame_abort_o)
    else $error("complete frame treated as abort");
  a_sync_high_min: assert property ($rose(sync_n) |-> sync_n[*8])
    else $error("select high time too short");
  a_gap_min: assert property ($fell(sync_n) |-> gap_cnt >= GAP_CYC)
    else $error("frame gap too short");
  a_clear_first: assert property (!sync_n |-> clear_n)
    else $error("frame open while clear held");

  c_open: cover property (seq_open);
endmodule // qdac_link_sva

// *** verification/testbench.sv ***
// Self-checking bench: host and converter pair, plus a hand-driven second converter
`timescale 1ns/1ps
module testbench;
  import qdac_pkg::*;
  localparam int HALF  = 4;
  localparam int BHALF = 16;
  logic                                sys_clk_i, reset_i, start_i, clear_i, level_select_i, load_all_i;
  logic [FRAME_BITS-1:0]               frame_i, cap;
  logic                                ready_o, busy_o, done_o, frame_done, frame_abort, done_b, abort_b;
  logic [CHANNELS-1:0][DATA_W-1:0]     dac_code, code_b;
  logic [CHANNELS-1:0]                 dac_pd;
  logic [CHANNELS-1:0][PD_MODE_W-1:0]  pd_mode;
  int                                  miscompares, checks, abort_cnt_b, done_cnt_b;

  qdac_link_if link ();
  qdac_link_if link_b ();
  qdac_host #(.SCLK_HALF(HALF)) u_qdac_host (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .link(link),
    .start_i(start_i), .frame_i(frame_i), .clear_i(clear_i), .level_select_i(level_select_i),
    .load_all_i(load_all_i), .ready_o(ready_o), .busy_o(busy_o), .done_o(done_o));
  qdac_device u_qdac_device (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .link(link), .dac_code_o(dac_code),
    .dac_pd_o(dac_pd), .dac_pd_mode_o(pd_mode), .frame_done_o(frame_done), .frame_abort_o(frame_abort));
  // Second converter takes deliberately broken framing from the bench
  qdac_device u_qdac_device_b (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .link(link_b), .dac_code_o(code_b),
    .dac_pd_o(), .dac_pd_mode_o(), .frame_done_o(done_b), .frame_abort_o(abort_b));
  qdac_link_sva #(.SCLK_HALF(HALF)) u_qdac_link_sva (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .sync_n(link.sync_n), .sclk(link.sclk), .din(link.din), .clear_n(link.clear_n),
    .frame_done_o(frame_done), .frame_abort_o(frame_abort));

  initial sys_clk_i = 1'b0;
  always #2.5 sys_clk_i = ~sys_clk_i;

  always @(posedge sys_clk_i) begin
    if (abort_b === 1'b1) abort_cnt_b++;
    if (done_b === 1'b1) done_cnt_b++;
  end
  always @(negedge link.sclk) begin
    if (link.sync_n === 1'b0) cap <= {cap[22:0], link.din};
  end

  task automatic complete_run;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk_code(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t: code %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bits(input logic [FRAME_BITS-1:0] got, input logic [FRAME_BITS-1:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t: value %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [23:0] frm(input logic [1:0] cmd, input logic [1:0] ch, input logic pd,
                                      input logic [15:0] d);
    return {2'h0, cmd, 1'b0, ch, pd, d};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask

  task automatic send(input logic [23:0] f);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    frame_i <= f;
    start_i <= 1'b1;
    @(posedge sys_clk_i);
    start_i <= 1'b0;
    @(negedge sys_clk_i);
    chk_bits(24'({busy_o, link.sync_n}), 24'h2);
    while (done_o !== 1'b1 && n < 2000) begin
      @(negedge sys_clk_i);
      n++;
    end
    if (n >= 2000) begin
      miscompares++;
      $display("ERROR %0t: frame never finished", $time);
    end
    tick(2);
    chk_bits(cap, f);
    chk_bits(24'({busy_o, ready_o, link.sync_n}), 24'h3);
  endtask

  // Bench drives sclk at 160 ns; data line shows the inverse once released
  task automatic drive_b(input logic [23:0] w, input int n, input bit open);
    if (open) begin
      @(posedge sys_clk_i);
      link_b.sync_n <= 1'b0;
    end
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk_i);
      link_b.sclk <= 1'b1;
      link_b.din <= w[23 - (i % 24)];
      repeat (BHALF) @(posedge sys_clk_i);
      link_b.sclk <= 1'b0;
      repeat (BHALF - 1) @(posedge sys_clk_i);
    end
    link_b.din <= ~link_b.din;
    tick(40);
  endtask

  task automatic t_commands;
    send(frm(LOAD_STORE, 2'h0, 1'b0, 16'h1234));
    chk_code(dac_code[0], 16'h0000);
    send(frm(LOAD_UPDATE, 2'h1, 1'b0, 16'habcd) | 24'h080000);
    chk_code(dac_code[1], 16'habcd);
    send(frm(LOAD_SIMUL, 2'h2, 1'b0, 16'hffff));
    chk_code(dac_code[0], 16'h1234);
    chk_code(dac_code[2], 16'hffff);
    chk_code(dac_code[1], 16'habcd);
    send(frm(LOAD_BCAST, 2'h2, 1'b0, 16'h0f0f));
    for (int c = 0; c < CHANNELS; c++) chk_code(dac_code[c], 16'h0f0f);
    send(frm(LOAD_STORE, 2'h3, 1'b0, 16'h7777));
    send(frm(LOAD_BCAST, 2'h1, 1'b0, 16'h5555));
    chk_code(dac_code[3], 16'h7777);
    chk_code(dac_code[1], 16'h0f0f);
  endtask

  task automatic t_strobe;
    send(frm(LOAD_STORE, 2'h0, 1'b0, 16'h2222));
    chk_code(dac_code[0], 16'h0f0f);
    @(posedge sys_clk_i);
    load_all_i <= 1'b1;
    tick(10);
    chk_code(dac_code[0], 16'h2222);
    @(posedge sys_clk_i);
    load_all_i <= 1'b0;
  endtask

  task automatic t_powerdown;
    for (int k = 0; k < 4; k++) begin
      send(frm(LOAD_UPDATE, 2'h1, 1'b1, {k[1:0], 14'h0}));
      chk_bits(24'(pd_mode[1]), 24'(k[1:0]));
      chk_bits(24'(dac_pd[1]), 24'h1);
    end
  endtask

  task automatic t_clear;
    @(posedge sys_clk_i);
    level_select_i <= 1'b1;
    tick(3);
    chk_code(dac_code[3], 16'hf777);
    @(posedge sys_clk_i);
    clear_i <= 1'b1;
    tick(3);
    for (int c = 0; c < CHANNELS; c++) chk_code(dac_code[c], 16'h8000);
    chk_bits(24'(dac_pd), 24'h0);
    chk_bits(24'(ready_o), 24'h0);
    @(posedge sys_clk_i);
    level_select_i <= 1'b0;
    tick(3);
    chk_code(dac_code[3], 16'h0000);
    @(posedge sys_clk_i);
    clear_i <= 1'b0;
    tick(4);
    send(frm(LOAD_UPDATE, 2'h0, 1'b0, 16'h4321));
    chk_code(dac_code[0], 16'h4321);
  endtask

  task automatic t_link_b;
    drive_b(frm(LOAD_UPDATE, 2'h0, 1'b0, 16'h3c3c), 10, 1'b1);
    @(posedge sys_clk_i);
    link_b.sync_n <= 1'b1;
    tick(20);
    chk_bits(24'(abort_cnt_b), 24'h1);
    chk_code(code_b[0], 16'h0000);
    drive_b(frm(LOAD_UPDATE, 2'h0, 1'b0, 16'h3c3c), 28, 1'b1);
    chk_code(code_b[0], 16'h3c3c);
    drive_b(frm(LOAD_UPDATE, 2'h0, 1'b0, 16'h5a5a), 24, 1'b0);
    chk_code(code_b[0], 16'h3c3c);
    @(posedge sys_clk_i);
    link_b.sync_n <= 1'b1;
    tick(20);
    chk_bits(24'(abort_cnt_b), 24'h1);
    chk_bits(24'(done_cnt_b), 24'h1);
  endtask

  initial begin
    reset_i = 1'b1;
    start_i = 1'b0;
    frame_i = 24'h000000;
    clear_i = 1'b0;
    level_select_i = 1'b0;
    load_all_i = 1'b0;
    link_b.sync_n = 1'b1;
    link_b.sclk = 1'b0;
    link_b.din = 1'b0;
    link_b.clear_n = 1'b1;
    link_b.clear_level_select = 1'b0;
    link_b.load_all_strobe = 1'b0;
    repeat (20) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    tick(10);
    t_commands();
    t_strobe();
    t_powerdown();
    t_clear();
    t_link_b();
    complete_run();
  end

  // Expected run is near 4900 cycles
  initial begin
    repeat (30000) @(posedge sys_clk_i);
    miscompares++;
    $display("ERROR %0t: watchdog expired", $time);
    complete_run();
  end
endmodule // testbench
